// [hw/asrc_defs.vh]
// Constants for the asynchronous static memory host controller
`ifndef ASRC_DEFS_VH
`define ASRC_DEFS_VH
// ********************************
// Geometry
// ********************************
`define ASRC_ADDR_W 14
// ********************************
// Timing in ns (speed grade 20)
// ********************************
`define ASRC_CLK_NS 20
`define ASRC_READ_CYCLE_MIN_NS 20
`define ASRC_ADDRESS_ACCESS_DELAY_NS 20
`define ASRC_ADDR_VALID_TO_WRITE_END_NS 16
`define ASRC_SELECT_TO_WRITE_END_NS 18
`define ASRC_STROBE_PULSE_WIDTH_NS 16
`define ASRC_POWER_DOWN_DELAY_NS 20
// ********************************
// Cycle counts: min rounds up, sample rounds up (+2 for input sync)
// ********************************
`define ASRC_CEIL(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_MAX2(a, b) (((a) > (b)) ? (a) : (b))
`define ASRC_WR_LOW_CYC `ASRC_MAX2(1, `ASRC_CEIL(`ASRC_MAX2(`ASRC_SELECT_TO_WRITE_END_NS, `ASRC_MAX2(`ASRC_ADDR_VALID_TO_WRITE_END_NS, `ASRC_STROBE_PULSE_WIDTH_NS))))
`define ASRC_RD_CYC `ASRC_MAX2(1, `ASRC_CEIL(`ASRC_ADDRESS_ACCESS_DELAY_NS))
`define ASRC_SYNC_CYC 2
`define ASRC_CNT_W 8
`endif

// [hw/asrc_sync.v]
// Two-flop synchroniser for the memory data-out pin
`timescale 1ns/1ns
`default_nettype none
module asrc_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end
  assign q_o = sync_reg;
endmodule
`default_nettype wire

// [hw/asrc_host.v]
// Host controller driving a 16K x 1 asynchronous static memory
//
// Function
// - Address changes only with strobe high
// - Write starts at later falling edge
// - Data-in held after write end
// - Cycle time at least access time
// - Address and strobe held before write end
// - Select held low before write end
// - Address may change once write ends
// - Strobe high around every read cycle
// - Deselect before retention, wait after; RETAIN_I only acts in idle, so an operation under way keeps select low
`timescale 1ns/1ns
`default_nettype none
`include "asrc_defs.vh"
module asrc_host #(
  parameter ADDR_W = `ASRC_ADDR_W
) (
  input  wire              REF_CLK_I,
  input  wire              RST_I,
  input  wire              REQ_I,
  input  wire              WRITE_I,
  input  wire [ADDR_W-1:0] ADDR_I,
  input  wire              WDATA_I,
  input  wire              RETAIN_I,
  output reg               BUSY_O,
  output reg               DONE_O,
  output reg               RDATA_O,
  output reg  [ADDR_W-1:0] MEM_ADDR_O,
  output reg               MEM_SEL_N_O,
  output reg               MEM_STROBE_N_O,
  output reg               MEM_DIN_O,
  input  wire              MEM_DOUT_I
);
  // ********************************
  // States
  // ********************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SETUP = 5'h02;
  localparam [4:0] ST_WRITE = 5'h04;
  localparam [4:0] ST_READ = 5'h08;
  localparam [4:0] ST_RECOV = 5'h10;
  // ********************************
  // Cycle counts
  // ********************************
  // Counts follow the grade set in the defines header
  localparam [31:0] WR_CYC_FULL    = `ASRC_WR_LOW_CYC;
  localparam [31:0] RD_CYC_FULL    = `ASRC_RD_CYC + `ASRC_SYNC_CYC;
  localparam [31:0] RECOV_CYC_FULL = `ASRC_CEIL(`ASRC_READ_CYCLE_MIN_NS);
  // Cut to the counter width on purpose; every count is small
  localparam [`ASRC_CNT_W-1:0] WR_CYC    = WR_CYC_FULL[`ASRC_CNT_W-1:0];
  localparam [`ASRC_CNT_W-1:0] RD_CYC    = RD_CYC_FULL[`ASRC_CNT_W-1:0];
  localparam [`ASRC_CNT_W-1:0] RECOV_CYC = RECOV_CYC_FULL[`ASRC_CNT_W-1:0];

  reg  [4:0]               state_reg;
  reg  [4:0]               state_next;
  reg  [`ASRC_CNT_W-1:0]   cnt_reg;
  reg  [`ASRC_CNT_W-1:0]   cnt_next;
  reg                      wr_reg;
  reg                      retain_seen_reg;
  wire                     dout_sync;

  // ********************************
  // Counter helpers
  // ********************************
  // Last cycle of any timed phase
  function cnt_last;
    input [`ASRC_CNT_W-1:0] c;
    cnt_last = (c == {{(`ASRC_CNT_W-1){1'b0}}, 1'b1});
  endfunction
  // One step down; never called on zero
  function [`ASRC_CNT_W-1:0] cnt_dec;
    input [`ASRC_CNT_W-1:0] c;
    cnt_dec = c - {{(`ASRC_CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // Pin from the memory is asynchronous to our clock
  // Costs two cycles of read latency, the price of a safe sample
  asrc_sync u_sync (
    .clk_i (REF_CLK_I),
    .rst_i (RST_I),
    .d_i   (MEM_DOUT_I),
    .q_o   (dout_sync)
  );

  // ********************************
  // Next state
  // ********************************
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        // Refused requests are dropped, not queued
        // retention holds deselect
        if (REQ_I && !RETAIN_I && !retain_seen_reg) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_next = wr_reg ? ST_WRITE : ST_READ;
        cnt_next = wr_reg ? WR_CYC : RD_CYC;
      end
      ST_WRITE: begin
        if (cnt_last(cnt_reg)) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      ST_READ: begin
        if (cnt_last(cnt_reg)) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      ST_RECOV: begin
        // one read cycle after supply returns
        if (cnt_last(cnt_reg)) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // recovery wins over a request in the same cycle
    if (state_reg == ST_IDLE && retain_seen_reg && !RETAIN_I) begin
      state_next = ST_RECOV;
      cnt_next = RECOV_CYC;
    end
  end

  // ********************************
  // Registers and pins
  // ********************************
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      // Pins park deselected, so the memory idles in standby
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      retain_seen_reg <= 1'b0;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
      RDATA_O <= 1'b0;
      MEM_ADDR_O <= {ADDR_W{1'b0}};
      MEM_SEL_N_O <= 1'b1;
      MEM_STROBE_N_O <= 1'b1;
      MEM_DIN_O <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      DONE_O <= 1'b0;
      if (state_reg == ST_IDLE) begin
        retain_seen_reg <= RETAIN_I;
      end
      // Busy covers recovery too, so callers wait it out
      BUSY_O <= (state_next != ST_IDLE);
      if (state_reg == ST_IDLE && state_next == ST_SETUP) begin
        // Address and data lead select by a whole clock,
        // well past the zero setup and hold the memory needs
        // address moves while deselected
        MEM_ADDR_O <= ADDR_I;
        MEM_DIN_O <= WDATA_I;
        wr_reg <= WRITE_I;
      end
      case (state_next)
        ST_WRITE: begin
          MEM_SEL_N_O <= 1'b0;
          MEM_STROBE_N_O <= 1'b0;
        end
        ST_READ: begin
          MEM_SEL_N_O <= 1'b0;
          MEM_STROBE_N_O <= 1'b1;
        end
        default: begin
          MEM_SEL_N_O <= 1'b1;
          MEM_STROBE_N_O <= 1'b1;
        end
      endcase
      if (state_reg == ST_READ && state_next == ST_IDLE) begin
        // RDATA stands until the next read completes
        // capture synchronised bit
        RDATA_O <= dout_sync;
        DONE_O <= 1'b1;
      end
      if (state_reg == ST_WRITE && state_next == ST_IDLE) begin
        // Strobe goes high on the same edge that raises DONE, so the write is complete
        // idle cycle pads cycle time
        DONE_O <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [test/asrc_chk.sv]
// Protocol checker for the memory host controller
`timescale 1ns/1ns
`default_nettype none
module asrc_chk (
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        RETAIN_I,
  input wire logic        BUSY_O,
  input wire logic        DONE_O,
  input wire logic [13:0] MEM_ADDR_O,
  input wire logic        MEM_SEL_N_O,
  input wire logic        MEM_STROBE_N_O,
  input wire logic        MEM_DIN_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  a_addr_hold: assert property (!MEM_STROBE_N_O |-> $stable(MEM_ADDR_O))
    else $error("addr moved");
  a_strobe_sel: assert property (!MEM_STROBE_N_O |-> !MEM_SEL_N_O)
    else $error("lone strobe");
  a_write_len: assert property ($fell(MEM_STROBE_N_O) |-> ##1
    MEM_STROBE_N_O && MEM_SEL_N_O && DONE_O) else $error("write len");
  a_din_hold: assert property (!MEM_STROBE_N_O || $rose(MEM_STROBE_N_O)
    |-> $stable(MEM_DIN_O)) else $error("din moved");
  a_read_len: assert property ($fell(MEM_SEL_N_O) && MEM_STROBE_N_O
    |-> !MEM_SEL_N_O[*3] ##1 MEM_SEL_N_O && DONE_O) else $error("read len");
  a_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("long done");
  a_busy_done: assert property ($rose(BUSY_O) &&
    !($past(RETAIN_I, 2) && !$past(BUSY_O, 2)) |-> ##[2:4] DONE_O)
    else $error("no done");
  a_recov_quiet: assert property ($rose(BUSY_O) && $past(RETAIN_I, 2)
    && !$past(BUSY_O, 2) |-> ##1 !BUSY_O && !DONE_O && MEM_SEL_N_O)
    else $error("recovery op");
  a_retain_idle: assert property (RETAIN_I && $past(RETAIN_I) &&
    !BUSY_O |=> MEM_SEL_N_O && !BUSY_O) else $error("retain busy");
endmodule
bind asrc_host asrc_chk asrc_chk_i (.REF_CLK_I, .RST_I, .RETAIN_I, .BUSY_O,
  .DONE_O, .MEM_ADDR_O, .MEM_SEL_N_O, .MEM_STROBE_N_O, .MEM_DIN_O);
`default_nettype wire

// [test/asrc_mem.sv]
// Behavioural 16K x 1 static memory at the host's far side
`timescale 1ns/1ns
`default_nettype none
module asrc_mem #(
  parameter int ACC_NS = 18
) (
  input  wire logic [13:0] addr_i,
  input  wire logic        sel_n_i,
  input  wire logic        strobe_n_i,
  input  wire logic        din_i,
  output wire logic        dout_o
);
  logic        mem [0:16383];
  wire  [14:0] now_w = {sel_n_i | ~strobe_n_i, addr_i};
  wire  [14:0] old_w;
  // Inertial delay, so any change restarts the access
  assign #(ACC_NS) old_w = now_w;
  always @* if (!sel_n_i && !strobe_n_i) mem[addr_i] = din_i;
  // deselect is standby; power is not modelled
  assign dout_o = (old_w == now_w && !now_w[14]) ? mem[addr_i]
                                                 : ~mem[addr_i];
endmodule
`default_nettype wire

// [test/asrc_host_tb_top.sv]
// Self-checking bench for the memory host controller
`timescale 1ns/1ns
`default_nettype none
module asrc_host_tb_top;
  logic        clk, rst, req, wr, wd, ret, busy, done, rd, sel_n, stb_n;
  logic        din, dout;
  logic [13:0] addr, ma;
  int          err_total, total_checks;
  asrc_host asrc_host_i (.REF_CLK_I(clk), .RST_I(rst), .REQ_I(req),
    .WRITE_I(wr), .ADDR_I(addr), .WDATA_I(wd), .RETAIN_I(ret),
    .BUSY_O(busy), .DONE_O(done), .RDATA_O(rd), .MEM_ADDR_O(ma),
    .MEM_SEL_N_O(sel_n), .MEM_STROBE_N_O(stb_n), .MEM_DIN_O(din),
    .MEM_DOUT_I(dout));
  asrc_mem asrc_mem_i (.addr_i(ma), .sel_n_i(sel_n), .strobe_n_i(stb_n),
    .din_i(din), .dout_o(dout));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %0h not %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One request, bounded wait for done, latency in cycles
  task automatic op(input logic w, input logic [13:0] a, input logic d,
                    input int cyc);
    int n;
    req = 1;
    wr = w;
    addr = a;
    wd = d;
    @(negedge clk);
    req = 0;
    n = 1;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n, cyc);
    if (n == 20) end_sim();
  endtask
  task automatic s_data;
    logic [13:0] a [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
    for (int i = 0; i < 4; i++) op(1, a[i], i[0] ^ i[1], 3);
    for (int i = 0; i < 4; i++) begin
      op(0, a[i], 0, 5);
      chk(rd, i[0] ^ i[1]);
    end
  endtask
  task automatic s_retain;
    ret = 1;
    req = 1;
    repeat (6) @(negedge clk);
    chk({busy, sel_n}, 2'b01);
    ret = 0;
    req = 0;
    repeat (2) @(negedge clk);
    op(0, 14'h3FFF, 0, 5);
    chk(rd, 1);
  endtask
  initial begin
    {req, wr, wd, ret} = 0;
    addr = 0;
    err_total = 0;
    total_checks = 0;
    rst = 1;
    repeat (4) @(negedge clk);
    rst = 0;
    s_data();
    s_retain();
    end_sim();
  end
endmodule
`default_nettype wire
